// ### design/lss_pkg.sv
package lss_pkg;

  // Register byte offsets in configuration space
  localparam logic [7:0] LSS_LINK_OFS = 8'hD0;
  localparam logic [7:0] LSS_SLOT_OFS = 8'hD4;

  // Link status half, field positions within the D0h word
  localparam int LSS_SPEED_LSB = 16;
  localparam int LSS_WIDTH_LSB = 20;
  localparam int LSS_TERR_BIT = 26;
  localparam int LSS_TRAIN_BIT = 27;
  localparam int LSS_SCLK_BIT = 28;
  localparam int LSS_DLACT_BIT = 29;

  // Slot_feature_caps field positions
  localparam int LSS_ATTN_BTN_BIT = 0;
  localparam int LSS_PWR_CTL_BIT = 1;
  localparam int LSS_ATTN_IND_BIT = 3;
  localparam int LSS_PWR_IND_BIT = 4;
  localparam int LSS_SURPRISE_BIT = 5;
  localparam int LSS_HP_CAP_BIT = 6;
  localparam int LSS_PVAL_LSB = 7;
  localparam int LSS_PSCL_LSB = 15;
  localparam int LSS_SLOTNUM_LSB = 19;

  // Writable bits of the hot-plug flag group (bit 2 reserved)
  localparam logic [6:0] LSS_CAP_FLAG_MASK = 7'h7B;

  // Speed codes and reset values
  localparam logic [3:0] LSS_SPEED_2G5 = 4'h1;
  localparam logic [3:0] LSS_SPEED_5G = 4'h2;
  localparam logic [3:0] LSS_SPEED_RST = 4'h2;
  localparam logic [5:0] LSS_WIDTH_RST = 6'h01;
  localparam logic [6:0] LSS_CAP_FLAGS_RST = 7'h00;
  localparam logic [7:0] LSS_PVAL_RST = 8'h00;
  localparam logic [1:0] LSS_PSCL_RST = 2'h0;
  localparam logic [12:0] LSS_SLOTNUM_RST = 13'h0000;

  // Edges after reset release before the synced strap is trusted
  localparam logic [1:0] LSS_STRAP_WAIT = 2'h2;

  typedef enum logic {LSS_ST_STRAP, LSS_ST_RUN} lss_phase_type;

endpackage : lss_pkg

// ### design/lss_sync.sv
module lss_sync
  import lss_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;
  logic sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : lss_sync

// ### design/lss_link_slot_regs.sv
module lss_link_slot_regs
  import lss_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic port_downstream,
  input wire logic slot_clock_strap,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  input wire logic ovr_wr,
  input wire logic [7:0] ovr_addr,
  input wire logic [3:0] ovr_be,
  input wire logic [31:0] ovr_wdata,
  input wire logic [3:0] link_speed_in,
  input wire logic [5:0] link_width_in,
  input wire logic train_start,
  input wire logic train_fail,
  input wire logic train_done_l0,
  input wire logic dl_active_in,
  input wire logic spl_msg_ack,
  output logic spl_msg_req,
  output logic [7:0] spl_msg_value,
  output logic [1:0] spl_msg_scale,
  output logic slot_clock_cfg
);

  typedef struct packed {
    lss_phase_type phase;
    logic [1:0] strap_cnt;
    logic [3:0] speed;
    logic [5:0] width;
    logic train_err;
    logic training;
    logic slot_clk;
    logic dl_active;
    logic [6:0] cap_flags;
    logic [7:0] pwr_val;
    logic [1:0] pwr_scl;
    logic [12:0] slot_num;
    logic msg_req;
    logic [31:0] rdata;
    logic rd_valid;
  } lss_state_type;

  lss_state_type state_ff;
  lss_state_type nxt_state;
  logic strap_sync;

  // Strap is a pin, so it crosses two flops first
  lss_sync u_strap_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(slot_clock_strap),
    .sync_out(strap_sync)
  );

  function automatic logic [31:0] lss_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction : lss_merge

  function automatic logic [31:0] lss_link_word(input lss_state_type s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[LSS_SPEED_LSB +: 4] = s.speed;
    w[LSS_WIDTH_LSB +: 6] = s.width;
    w[LSS_TERR_BIT] = s.train_err;
    w[LSS_TRAIN_BIT] = s.training;
    w[LSS_SCLK_BIT] = s.slot_clk;
    w[LSS_DLACT_BIT] = s.dl_active;
    // Bits 31:30 and the control half stay zero here
    return w;
  endfunction : lss_link_word

  function automatic logic [31:0] lss_slot_word(input lss_state_type s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[6:0] = s.cap_flags & LSS_CAP_FLAG_MASK;
    w[LSS_PVAL_LSB +: 8] = s.pwr_val;
    w[LSS_PSCL_LSB +: 2] = s.pwr_scl;
    w[LSS_SLOTNUM_LSB +: 13] = s.slot_num;
    return w;
  endfunction : lss_slot_word

  logic cfg_slot_hit;
  logic pwr_touch;
  logic ovr_link_hit;
  logic ovr_slot_hit;
  logic [31:0] cfg_slot_merged;
  logic [31:0] ovr_slot_merged;
  logic [31:0] read_word;

  always_comb begin
    cfg_slot_hit = cfg_wr && (cfg_addr == LSS_SLOT_OFS) && port_downstream;
    // Bytes 0..2 hold bits 7..16, the power limit fields
    pwr_touch = cfg_slot_hit && (cfg_be[0] || cfg_be[1] || cfg_be[2]);
    ovr_link_hit = ovr_wr && (ovr_addr == LSS_LINK_OFS) && ovr_be[3];
    ovr_slot_hit = ovr_wr && (ovr_addr == LSS_SLOT_OFS);
    cfg_slot_merged = lss_merge(lss_slot_word(state_ff), cfg_wdata, cfg_be);
    ovr_slot_merged = lss_merge(lss_slot_word(state_ff), ovr_wdata, ovr_be);
    if (cfg_addr == LSS_LINK_OFS) begin
      read_word = lss_link_word(state_ff);
    end else if (cfg_addr == LSS_SLOT_OFS && port_downstream) begin
      read_word = lss_slot_word(state_ff);
    end else begin
      // Unmapped offsets and upstream slot reads return zero
      read_word = 32'h0000_0000;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rd_valid = 1'b0;

    // Strap capture waits for the synchroniser to fill
    case (state_ff.phase)
      LSS_ST_STRAP: begin
        if (state_ff.strap_cnt == LSS_STRAP_WAIT) begin
          nxt_state.slot_clk = strap_sync;
          nxt_state.phase = LSS_ST_RUN;
        end else begin
          nxt_state.strap_cnt = state_ff.strap_cnt + 2'h1;
        end
      end
      LSS_ST_RUN: begin
        nxt_state.strap_cnt = state_ff.strap_cnt;
      end
      default: begin
        nxt_state.phase = LSS_ST_RUN;
      end
    endcase

    // Training in progress; a fresh start beats completion
    if (train_done_l0 || train_fail) begin
      nxt_state.training = 1'b0;
    end
    if (train_start) begin
      nxt_state.training = 1'b1;
    end

    // Error clears on L0; a failure in the same cycle wins
    if (train_done_l0) begin
      nxt_state.train_err = 1'b0;
    end
    if (train_fail) begin
      nxt_state.train_err = 1'b1;
    end

    // Rate and width only latched once training settles
    if (train_done_l0) begin
      if (link_speed_in == LSS_SPEED_2G5 || link_speed_in == LSS_SPEED_5G) begin
        nxt_state.speed = link_speed_in;
      end
      nxt_state.width = link_width_in;
    end

    nxt_state.dl_active = dl_active_in;

    // Only the power limit fields take configuration writes
    if (cfg_slot_hit) begin
      nxt_state.pwr_val = cfg_slot_merged[LSS_PVAL_LSB +: 8];
      nxt_state.pwr_scl = cfg_slot_merged[LSS_PSCL_LSB +: 2];
      // Flags, slot number and reserved bits left alone
    end

    // Message request holds until acked; a new write wins the ack
    if (spl_msg_ack) begin
      nxt_state.msg_req = 1'b0;
    end
    if (pwr_touch) begin
      nxt_state.msg_req = 1'b1;
    end

    // Side-band loads come last so they win over config writes
    if (ovr_link_hit) begin
      nxt_state.slot_clk = ovr_wdata[LSS_SCLK_BIT];
    end
    if (ovr_slot_hit) begin
      nxt_state.cap_flags = ovr_slot_merged[6:0] & LSS_CAP_FLAG_MASK;
      nxt_state.pwr_val = ovr_slot_merged[LSS_PVAL_LSB +: 8];
      nxt_state.pwr_scl = ovr_slot_merged[LSS_PSCL_LSB +: 2];
      nxt_state.slot_num = ovr_slot_merged[LSS_SLOTNUM_LSB +: 13];
    end

    if (cfg_rd) begin
      nxt_state.rdata = read_word;
      nxt_state.rd_valid = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff.phase <= LSS_ST_STRAP;
      state_ff.strap_cnt <= 2'h0;
      state_ff.speed <= LSS_SPEED_RST;
      state_ff.width <= LSS_WIDTH_RST;
      state_ff.train_err <= 1'b0;
      state_ff.training <= 1'b0;
      state_ff.slot_clk <= 1'b0;
      state_ff.dl_active <= 1'b0;
      state_ff.cap_flags <= LSS_CAP_FLAGS_RST;
      state_ff.pwr_val <= LSS_PVAL_RST;
      state_ff.pwr_scl <= LSS_PSCL_RST;
      state_ff.slot_num <= LSS_SLOTNUM_RST;
      state_ff.msg_req <= 1'b0;
      state_ff.rdata <= 32'h0000_0000;
      state_ff.rd_valid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Flag bits: set only by side-band load
  assign cfg_rdata = state_ff.rdata;
  assign cfg_rd_valid = state_ff.rd_valid;
  assign spl_msg_req = state_ff.msg_req;
  assign spl_msg_value = state_ff.pwr_val;
  assign spl_msg_scale = state_ff.pwr_scl;
  assign slot_clock_cfg = state_ff.slot_clk;

endmodule : lss_link_slot_regs

// ### bench/lss_link_slot_regs_asserts.sv
module lss_link_slot_regs_asserts
  import lss_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic port_downstream,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic ovr_wr,
  input wire logic spl_msg_ack,
  input wire logic spl_msg_req,
  input wire logic [7:0] spl_msg_value,
  input wire logic [1:0] spl_msg_scale
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Any power field byte counts, even an unchanged value
  wire pw = cfg_wr && port_downstream && cfg_addr == LSS_SLOT_OFS
    && |cfg_be[2:0];
  sequence s_pwr;
    pw && !ovr_wr;
  endsequence
  sequence s_rd(logic [7:0] a);
    cfg_rd && cfg_addr == a;
  endsequence
  chk_msg_raise: assert property (
    s_pwr |=> spl_msg_req) else $error("no message after write");
  chk_msg_quiet: assert property (
    !spl_msg_req && !pw |=> !spl_msg_req) else $error("stray message");
  chk_msg_hold: assert property (
    spl_msg_req && !spl_msg_ack |=> spl_msg_req) else $error("message lost");
  chk_value_write: assert property (
    s_pwr ##0 cfg_be[1:0] == 2'h3 |=> spl_msg_value == $past(cfg_wdata[14:7]))
    else $error("value not written");
  chk_scale_write: assert property (
    s_pwr ##0 cfg_be[2:1] == 2'h3
    |=> spl_msg_scale == $past(cfg_wdata[16:15])) else $error("scale bad");
  chk_power_hold: assert property (
    !cfg_wr && !ovr_wr |=> $stable(spl_msg_value) && $stable(spl_msg_scale))
    else $error("power fields moved");
  chk_link_rsvd: assert property (
    s_rd(LSS_LINK_OFS) |=> cfg_rdata[31:30] == 2'h0) else $error("rsvd set");
  chk_slot_rsvd: assert property (
    s_rd(LSS_SLOT_OFS) |=> !cfg_rdata[2] && cfg_rdata[18:17] == 2'h0)
    else $error("slot rsvd set");
  chk_up_hidden: assert property (
    s_rd(LSS_SLOT_OFS) ##0 !port_downstream |=> cfg_rdata == 32'h0)
    else $error("slot caps seen upstream");
endmodule : lss_link_slot_regs_asserts

// ### bench/lss_link_slot_regs_test.sv
module lss_link_slot_regs_test;
  import lss_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'h0, rst_n = 1'h0, port_downstream = 1'h1;
  logic slot_clock_strap = 1'h1, cfg_wr = 1'h0, cfg_rd = 1'h0;
  logic [7:0] cfg_addr = 8'h00, ovr_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0, ovr_be = 4'h0, link_speed_in = 4'h2;
  logic [31:0] cfg_wdata = 32'h0, ovr_wdata = 32'h0, cfg_rdata;
  logic ovr_wr = 1'h0, train_start = 1'h0, train_fail = 1'h0;
  logic train_done_l0 = 1'h0, dl_active_in = 1'h0, spl_msg_ack = 1'h0;
  logic [5:0] link_width_in = 6'h01;
  logic cfg_rd_valid, spl_msg_req, slot_clock_cfg;
  logic [7:0] spl_msg_value;
  logic [1:0] spl_msg_scale;
  int err_total = 0, checked = 0, cycles = 0;
  lss_link_slot_regs dut (.*);
  initial forever #12.5 clock = ~clock;
  task complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Hang guard, tests need under a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      complete_run;
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    checked++;
    if (seen !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, e, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clock);
    cfg_wr = 1'h1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clock);
    cfg_wr = 1'h0;
  endtask : wr
  task ov(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clock);
    ovr_wr = 1'h1;
    ovr_addr = a;
    ovr_be = be;
    ovr_wdata = d;
    @(negedge clock);
    ovr_wr = 1'h0;
  endtask : ov
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(negedge clock);
    cfg_rd = 1'h1;
    cfg_addr = a;
    @(negedge clock);
    cfg_rd = 1'h0;
    chk("rd_valid", cfg_rd_valid, 32'h1);
    chk(nm, cfg_rdata, e);
  endtask : rd_chk
  // Bits: ack, start, fail, done
  task ev(input logic [3:0] k);
    @(negedge clock);
    {spl_msg_ack, train_start, train_fail, train_done_l0} = k;
    @(negedge clock);
    {spl_msg_ack, train_start, train_fail, train_done_l0} = 4'h0;
  endtask : ev
  task t_reset;
    rd_chk("link", LSS_LINK_OFS, 32'h1012_0000);
    rd_chk("slot", LSS_SLOT_OFS, 32'h0);
    chk("sclk", slot_clock_cfg, 32'h1);
    $display("reset test done");
  endtask : t_reset
  task t_train;
    ev(4'h4);
    rd_chk("training", LSS_LINK_OFS, 32'h1812_0000);
    ev(4'h2);
    rd_chk("failed", LSS_LINK_OFS, 32'h1412_0000);
    link_speed_in = 4'h1;
    link_width_in = 6'h04;
    ev(4'h4);
    ev(4'h1);
    rd_chk("l0", LSS_LINK_OFS, 32'h1041_0000);
    dl_active_in = 1'h1;
    rd_chk("active", LSS_LINK_OFS, 32'h3041_0000);
    wr(LSS_LINK_OFS, 4'hF, 32'hFFFF_FFFF);
    rd_chk("ro_link", LSS_LINK_OFS, 32'h3041_0000);
    link_speed_in = 4'h2;
    link_width_in = 6'h08;
    ev(4'h1);
    dl_active_in = 1'h0;
    rd_chk("gen2", LSS_LINK_OFS, 32'h1082_0000);
    $display("training test done");
  endtask : t_train
  task t_slot;
    wr(LSS_SLOT_OFS, 4'hF, 32'hFFFF_FFFF);
    chk("req", spl_msg_req, 32'h1);
    chk("value", spl_msg_value, 32'hFF);
    chk("scale", spl_msg_scale, 32'h3);
    rd_chk("slot_rw", LSS_SLOT_OFS, 32'h0001_FF80);
    ev(4'h8);
    chk("req_ack", spl_msg_req, 32'h0);
    wr(LSS_SLOT_OFS, 4'h8, 32'h0);
    chk("req_ro", spl_msg_req, 32'h0);
    wr(LSS_SLOT_OFS, 4'h1, 32'h0);
    chk("req_b0", spl_msg_req, 32'h1);
    rd_chk("slot_b0", LSS_SLOT_OFS, 32'h0001_FF00);
    ev(4'h8);
    $display("slot test done");
  endtask : t_slot
  task t_ovr;
    ov(LSS_SLOT_OFS, 4'hF, 32'hFFFF_FFFF);
    rd_chk("ovr", LSS_SLOT_OFS, 32'hFFF9_FFFB);
    chk("ovr_req", spl_msg_req, 32'h0);
    chk("ovr_val", spl_msg_value, 32'hFF);
    ov(LSS_LINK_OFS, 4'h8, 32'h0);
    chk("sclk_ovr", slot_clock_cfg, 32'h0);
    rd_chk("link_ovr", LSS_LINK_OFS, 32'h0082_0000);
    $display("override test done");
  endtask : t_ovr
  task t_up;
    port_downstream = 1'h0;
    rd_chk("up_slot", LSS_SLOT_OFS, 32'h0);
    wr(LSS_SLOT_OFS, 4'hF, 32'h0);
    chk("up_req", spl_msg_req, 32'h0);
    port_downstream = 1'h1;
    rd_chk("dn_slot", LSS_SLOT_OFS, 32'hFFF9_FFFB);
    $display("upstream test done");
  endtask : t_up
  task t_race;
    link_speed_in = 4'h3;
    link_width_in = 6'h02;
    ev(4'h3);
    rd_chk("fail_wins", LSS_LINK_OFS, 32'h0422_0000);
    ev(4'h5);
    rd_chk("start_wins", LSS_LINK_OFS, 32'h0822_0000);
    wr(LSS_SLOT_OFS, 4'h1, 32'h0);
    chk("req_set", spl_msg_req, 32'h1);
    @(negedge clock);
    cfg_wr = 1'h1;
    cfg_addr = LSS_SLOT_OFS;
    cfg_be = 4'h1;
    cfg_wdata = 32'h0;
    spl_msg_ack = 1'h1;
    @(negedge clock);
    cfg_wr = 1'h0;
    spl_msg_ack = 1'h0;
    chk("req_wr_wins", spl_msg_req, 32'h1);
    ev(4'h8);
    chk("req_clr", spl_msg_req, 32'h0);
    $display("race test done");
  endtask : t_race
  task t_rst;
    slot_clock_strap = 1'h0;
    @(negedge clock);
    rst_n = 1'h0;
    repeat (5) @(negedge clock);
    rst_n = 1'h1;
    repeat (4) @(negedge clock);
    chk("rst_req", spl_msg_req, 32'h0);
    chk("rst_val", spl_msg_value, 32'h0);
    chk("rst_scl", spl_msg_scale, 32'h0);
    chk("rst_sclk", slot_clock_cfg, 32'h0);
    rd_chk("rst_link", LSS_LINK_OFS, 32'h0012_0000);
    rd_chk("rst_slot", LSS_SLOT_OFS, 32'h0);
    $display("mid-run reset test done");
  endtask : t_rst
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'h1;
    repeat (4) @(negedge clock);
    t_reset;
    t_train;
    t_slot;
    t_ovr;
    t_up;
    t_race;
    t_rst;
    complete_run;
  end
endmodule : lss_link_slot_regs_test
bind lss_link_slot_regs lss_link_slot_regs_asserts u_chk (.*);
